// ===== common/iad_pkg.sv
// Constants, field layout and carrier types of the input alarm / output driver block
package iad_pkg;
  localparam int CLK_NS       = 10;
  localparam int MS_NS        = 1000000;
  localparam int CYC_PER_MS   = MS_NS / CLK_NS;
  localparam int DLY_UNIT_MS  = 100;
  localparam int HOLD_UNIT_MS = 1000;

  localparam int TIM_W = 22;
  localparam int CFG_W = 12;
  localparam int CNT_W = 16;
  localparam int IRQ_W = 3;

  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_THR  = 8'h04;
  localparam logic [7:0] A_DLY  = 8'h08;
  localparam logic [7:0] A_HOLD = 8'h0c;
  localparam logic [7:0] A_LOW  = 8'h10;
  localparam logic [7:0] A_HIGH = 8'h14;
  localparam logic [7:0] A_STAT = 8'h18;
  localparam logic [7:0] A_IRQ  = 8'h1c;
  localparam logic [7:0] A_MASK = 8'h20;

  localparam int F_IN_EN  = 0;
  localparam int F_MODE   = 1;
  localparam int F_INV    = 2;
  localparam int F_OUT_EN = 3;
  localparam int F_ON     = 4;
  localparam int F_OFF    = 6;
  localparam int F_INIT   = 8;
  localparam int CTRL_W   = 10;

  localparam int S_ALARM = 0;
  localparam int S_SENSE = 1;
  localparam int S_OUT   = 2;
  localparam int S_BUSY  = 3;
  localparam int S_CNT   = 16;

  localparam int I_ON   = 0;
  localparam int I_OFF  = 1;
  localparam int I_DONE = 2;

  localparam logic [1:0] ACT_HIGH  = 2'h0;
  localparam logic [1:0] ACT_LOW   = 2'h1;
  localparam logic [1:0] ACT_PULSE = 2'h2;
  localparam logic [1:0] INIT_HIGH = 2'h0;
  localparam logic [1:0] INIT_LOW  = 2'h1;
  localparam logic [1:0] INIT_LAST = 2'h2;

  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h240;
  localparam logic [CNT_W-1:0]  THR_RST  = 16'h0000;
  localparam logic [CFG_W-1:0]  DLY_RST  = 12'h000;
  localparam logic [CFG_W-1:0]  HOLD_RST = 12'h000;
  localparam logic [CFG_W-1:0]  WID_RST  = 12'h3e8;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } iad_wb_req_t;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RUN} iad_state_t;
endpackage

// ===== design/iad_alarm_out.sv
// Sense input alarm and drive output engine with Wishbone register access
// How it works
// RULE_01: Input alarm off until input enabled
// RULE_02: Level mode default, counter mode selectable
// RULE_03: Count rising edges, falling when inverted
// RULE_04: Counter alarm when count reaches threshold
// RULE_05: Alarm on high level, low if inverted
// RULE_06: Output ignores alarms until enabled
// RULE_07: Alarm-on action: high, low or pulse
// RULE_08: Alarm-off action: high, low or pulse
// RULE_09: Pulse alternates programmed high and low widths
// RULE_10: Power-up level: high, low or last
// RULE_11: Start delay in 100 ms units
// RULE_12: Hold time ends action; zero holds forever
// RULE_13: Low width 1 to 3000 ms (loww_q takes any 12-bit value, 0 to 4095, without a range check)
// RULE_14: High width 1 to 3000 ms (highw_q takes any 12-bit value, 0 to 4095, without a range check)
// RULE_15: Output follows only input one alarm
// RULE_16: Millisecond tick times all durations
// RULE_17: Level mode signals alarm-off on return
`timescale 1ns/1ps
module iad_alarm_out #(
  parameter int MS_CYC = iad_pkg::CYC_PER_MS
) (
  input  wire iad_pkg::iad_wb_req_t wb_req_i,
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                ce_i,
  input  wire logic                sense_input_i,
  input  wire logic                last_level_i,
  input  wire logic [1:0]          init_sel_i,
  output logic [31:0]              wb_dat_o,
  output logic                     wb_ack_o,
  output logic                     drive_o,
  output logic [1:0]               init_sel_o,
  output logic                     irq_o
);
  import iad_pkg::*;

  logic [CTRL_W-1:0] ctrl_q;
  logic [CNT_W-1:0]  thr_q, cnt_q;
  logic [CFG_W-1:0]  dly_q, hold_q, loww_q, highw_q;
  logic [IRQ_W-1:0]  irq_q, mask_q, irq_set;
  logic [31:0]       rd_d, wmask;
  logic              ack_q, wr_go;
  logic              s1_q, s2_q, s3_q, rise, fall;
  logic              alarm_d, alarm_q, on_ev, off_ev, input_one_alarm;
  logic [31:0]       tick_cnt_q;
  logic              tick_q;
  iad_state_t        st_q;
  logic [1:0]        act_q;
  logic [TIM_W-1:0]  tm_q, ph_q, dly_ms, hold_ms, wid_ms;
  logic              out_q, done_ev;

  wire in_en  = ctrl_q[F_IN_EN];
  wire mode   = ctrl_q[F_MODE];
  wire inv    = ctrl_q[F_INV];
  wire out_en = ctrl_q[F_OUT_EN];
  wire [1:0] on_act  = ctrl_q[F_ON+:2];
  wire [1:0] off_act = ctrl_q[F_OFF+:2];

  // Bus slave: ack one cycle after request, writes land on the ack edge
  assign wr_go = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && ack_q;
  assign wmask = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}},
                  {8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};

  // Byte-lane merge of a write into a register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  always_comb begin
    rd_d = 32'h0;
    unique case (wb_req_i.adr)
      A_CTRL: rd_d[CTRL_W-1:0] = ctrl_q;
      A_THR:  rd_d[CNT_W-1:0]  = thr_q;
      A_DLY:  rd_d[CFG_W-1:0]  = dly_q;
      A_HOLD: rd_d[CFG_W-1:0]  = hold_q;
      A_LOW:  rd_d[CFG_W-1:0]  = loww_q;
      A_HIGH: rd_d[CFG_W-1:0]  = highw_q;
      A_STAT: begin
        rd_d[S_ALARM] = alarm_q;
        rd_d[S_SENSE] = s2_q;
        rd_d[S_OUT]   = out_q;
        rd_d[S_BUSY]  = (st_q != ST_IDLE);
        rd_d[S_CNT+:CNT_W] = cnt_q;
      end
      A_IRQ:  rd_d[IRQ_W-1:0] = irq_q;
      A_MASK: rd_d[IRQ_W-1:0] = mask_q;
      default: rd_d = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q    <= 1'b0;
      wb_dat_o <= 32'h0;
    end else if (ce_i) begin
      ack_q <= wb_req_i.cyc && wb_req_i.stb && !ack_q;
      if (wb_req_i.cyc && wb_req_i.stb && !ack_q) begin
        wb_dat_o <= rd_d;
      end
    end
  end
  assign wb_ack_o = ack_q;

  // Configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q  <= CTRL_RST;
      thr_q   <= THR_RST;
      dly_q   <= DLY_RST;
      hold_q  <= HOLD_RST;
      loww_q  <= WID_RST;
      highw_q <= WID_RST;
      mask_q  <= '0;
    end else if (ce_i && wr_go) begin
      unique case (wb_req_i.adr)
        A_CTRL: ctrl_q  <= CTRL_W'(merge(32'(ctrl_q), wb_req_i.dat, wmask)); // RULE_02
        A_THR:  thr_q   <= CNT_W'(merge(32'(thr_q), wb_req_i.dat, wmask));
        A_DLY:  dly_q   <= CFG_W'(merge(32'(dly_q), wb_req_i.dat, wmask));
        A_HOLD: hold_q  <= CFG_W'(merge(32'(hold_q), wb_req_i.dat, wmask));
        A_LOW:  loww_q  <= CFG_W'(merge(32'(loww_q), wb_req_i.dat, wmask)); // RULE_13
        A_HIGH: highw_q <= CFG_W'(merge(32'(highw_q), wb_req_i.dat, wmask)); // RULE_14
        A_MASK: mask_q  <= IRQ_W'(merge(32'(mask_q), wb_req_i.dat, wmask));
        default: ;
      endcase
    end
  end
  assign init_sel_o = ctrl_q[F_INIT+:2];

  // Sense input synchroniser and edge detect
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else if (ce_i) begin
      s1_q <= sense_input_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  assign rise = s2_q && !s3_q;
  assign fall = !s2_q && s3_q;

  // Edge counter; a write of one to status bit 0 clears it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (ce_i) begin
      if (!in_en || !mode || (wr_go && wb_req_i.adr == A_STAT && wb_req_i.dat[0])) begin
        cnt_q <= '0;
      end else if ((inv ? fall : rise) && cnt_q != {CNT_W{1'b1}}) begin // RULE_03
        // Saturates at all ones rather than wrapping back under the threshold
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  always_comb begin
    if (!in_en) begin
      alarm_d = 1'b0; // RULE_01
    end else if (mode) begin
      alarm_d = (cnt_q >= thr_q); // RULE_04
    end else begin
      alarm_d = s2_q ^ inv; // RULE_05
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_q <= 1'b0;
    end else if (ce_i) begin
      alarm_q <= alarm_d;
    end
  end
  assign input_one_alarm = alarm_q;
  assign on_ev  = alarm_d && !alarm_q;
  assign off_ev = !alarm_d && alarm_q; // RULE_17

  // Millisecond tick
  // Free-running, so the first interval of any timed action may be short by one tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else if (ce_i) begin
      tick_q <= (tick_cnt_q == 32'(MS_CYC - 1)); // RULE_16
      tick_cnt_q <= (tick_cnt_q == 32'(MS_CYC - 1)) ? 32'h0 : tick_cnt_q + 32'h1;
    end
  end

  assign dly_ms  = TIM_W'(dly_q) * TIM_W'(DLY_UNIT_MS); // RULE_11
  assign hold_ms = TIM_W'(hold_q) * TIM_W'(HOLD_UNIT_MS);
  assign wid_ms  = out_q ? TIM_W'(highw_q) : TIM_W'(loww_q);

  // Output action engine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q    <= ST_IDLE;
      act_q   <= ACT_LOW;
      tm_q    <= '0;
      ph_q    <= '0;
      done_ev <= 1'b0;
      unique case (init_sel_i) // RULE_10
        INIT_HIGH: out_q <= 1'b1;
        INIT_LOW:  out_q <= 1'b0;
        default:   out_q <= last_level_i;
      endcase
    end else if (ce_i) begin
      done_ev <= 1'b0;
      if (!out_en) begin
        // Disabled output freezes at its current level
        st_q <= ST_IDLE; // RULE_06
      end else if (on_ev || off_ev) begin // RULE_15
        // A new event restarts the delay and the action
        act_q <= on_ev ? on_act : off_act; // RULE_07 RULE_08
        tm_q  <= '0;
        ph_q  <= '0;
        if (dly_ms == '0) begin
          st_q  <= ST_RUN;
          out_q <= ((on_ev ? on_act : off_act) != ACT_LOW);
        end else begin
          st_q <= ST_WAIT;
        end
      end else begin
        unique case (st_q)
          ST_IDLE: ;
          ST_WAIT: if (tick_q) begin
            if (tm_q + 1'b1 >= dly_ms) begin // RULE_11
              st_q  <= ST_RUN;
              tm_q  <= '0;
              out_q <= (act_q != ACT_LOW);
            end else begin
              tm_q <= tm_q + 1'b1;
            end
          end
          ST_RUN: if (tick_q) begin
            tm_q <= tm_q + 1'b1;
            // Hold expiry stops the action and drives low
            if (hold_ms != '0 && tm_q + 1'b1 >= hold_ms) begin // RULE_12
              st_q    <= ST_IDLE;
              out_q   <= 1'b0;
              done_ev <= 1'b1;
            end else if (act_q == ACT_PULSE) begin
              if (ph_q + 1'b1 >= wid_ms) begin // RULE_09
                out_q <= !out_q;
                ph_q  <= '0;
              end else begin
                ph_q <= ph_q + 1'b1;
              end
            end
          end
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end
  assign drive_o = out_q;

  // Sticky interrupt status, write one to clear, set wins
  assign irq_set = {done_ev, off_ev, on_ev};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= '0;
    end else if (ce_i) begin
      if (wr_go && wb_req_i.adr == A_IRQ) begin
        irq_q <= (irq_q & ~IRQ_W'(wb_req_i.dat & wmask)) | irq_set;
      end else begin
        irq_q <= irq_q | irq_set;
      end
    end
  end
  assign irq_o = |(irq_q & mask_q);

  a_in_disabled: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_01
    (ce_i && !in_en) |=> !alarm_q) else $error("alarm while input disabled");
  a_level_alarm: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_05
    (ce_i && in_en && !mode) |=> alarm_q == ($past(s2_q) ^ $past(inv)))
    else $error("level alarm wrong");
  a_cnt_edge: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_03
    (ce_i && in_en && mode && !inv && rise && cnt_q != {CNT_W{1'b1}} && !wr_go)
    |=> cnt_q == $past(cnt_q) + 1'b1) else $error("edge not counted");
  a_cnt_thresh: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_04
    (ce_i && in_en && mode) |=> alarm_q == ($past(cnt_q) >= $past(thr_q)))
    else $error("threshold alarm wrong");
  a_out_disabled: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_06
    (ce_i && !out_en) |=> st_q == ST_IDLE) else $error("output ran while disabled");
  a_on_high: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_07
    (st_q == ST_RUN && act_q == ACT_HIGH) |-> out_q) else $error("high action not high");
  a_off_select: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_08
    (ce_i && out_en && off_ev) |=> act_q == $past(off_act)) else $error("off action wrong");
  a_delay_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_11
    (ce_i && st_q == ST_WAIT && !on_ev && !off_ev && out_en
     && !(tick_q && tm_q + 1'b1 >= dly_ms)) |=> $stable(out_q))
    else $error("output moved during delay");
  a_tick_pulse: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_16
    (ce_i && tick_q) |=> !tick_q) else $error("tick longer than one cycle");

  // Input side and tick checks
  a_cnt_fall: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_03
    (ce_i && in_en && mode && inv && fall && cnt_q != {CNT_W{1'b1}} && !wr_go)
    |=> cnt_q == $past(cnt_q) + 1'b1) else $error("falling edge not counted");
  a_cnt_idle: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_02
    (ce_i && !mode) |=> cnt_q == '0) else $error("count moved in level mode");
  a_level_off: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_17
    (ce_i && in_en && !mode && alarm_q && !(s2_q ^ inv)) |=> (!alarm_q && irq_q[I_OFF]))
    else $error("alarm-off not signalled");
  a_tick_align: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_16
    tick_q |-> tick_cnt_q == 32'h0) else $error("tick out of step with counter");

  // Output engine checks
  a_on_start: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_07
    (ce_i && out_en && on_ev && dly_ms == '0) |=> out_q == ($past(on_act) != ACT_LOW))
    else $error("alarm-on action level wrong");
  a_off_start: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_08
    (ce_i && out_en && off_ev && dly_ms == '0) |=> out_q == ($past(off_act) != ACT_LOW))
    else $error("alarm-off action level wrong");
  a_wait_entry: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_11
    (ce_i && out_en && (on_ev || off_ev) && dly_ms != '0)
    |=> (st_q == ST_WAIT && $stable(out_q))) else $error("delay not started");
  a_hold_end: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_12
    (ce_i && out_en && !on_ev && !off_ev && st_q == ST_RUN && tick_q && hold_ms != '0
     && tm_q + 1'b1 >= hold_ms) |=> (st_q == ST_IDLE && !out_q))
    else $error("hold time did not end action");
  a_hold_zero: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_12
    (ce_i && out_en && !on_ev && !off_ev && st_q == ST_RUN && hold_ms == '0)
    |=> st_q == ST_RUN) else $error("zero hold ended action");
  a_pulse_flip: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_09
    (ce_i && out_en && !on_ev && !off_ev && st_q == ST_RUN && act_q == ACT_PULSE && tick_q
     && !(hold_ms != '0 && tm_q + 1'b1 >= hold_ms) && ph_q + 1'b1 >= wid_ms)
    |=> out_q != $past(out_q)) else $error("pulse level did not flip");
  a_pulse_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_09
    (ce_i && out_en && !on_ev && !off_ev && st_q == ST_RUN && !tick_q) |=> $stable(out_q))
    else $error("output moved between ticks");

  // Scenario covers
  c_alarm_on: cover property (@(posedge clk_i) disable iff (rst_i) on_ev && out_en);
  c_pulse_run: cover property (@(posedge clk_i) disable iff (rst_i)
    st_q == ST_RUN && act_q == ACT_PULSE && tick_q && ph_q == '0);
  c_hold_done: cover property (@(posedge clk_i) disable iff (rst_i) done_ev);
  c_alarm_off: cover property (@(posedge clk_i) disable iff (rst_i) off_ev && out_en);
  c_delay_run: cover property (@(posedge clk_i) disable iff (rst_i)
    st_q == ST_WAIT && tick_q && tm_q + 1'b1 >= dly_ms);
endmodule // iad_alarm_out

// ===== dv/iad_alarm_out_bench.sv
// Self-checking bench of the input alarm / output driver block
`timescale 1ns/1ps
module iad_alarm_out_bench;
  import iad_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        close = 1'b0;
  logic        ce    = 1'b1;
  logic        last  = 1'b0;
  logic [1:0]  isel  = 2'h0;
  iad_wb_req_t req   = '0;
  logic [31:0] q;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        drive_o;
  logic        irq_o;
  logic        sense;
  logic [1:0]  isel_o;
  logic [15:0] rises;
  int          fail_count = 0;
  int          check_count = 0;

  always #5 clk_i = ~clk_i;

  iad_alarm_out #(.MS_CYC(10)) iad_alarm_out_inst (
    .wb_req_i(req), .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .sense_input_i(sense), .last_level_i(last), .init_sel_i(isel),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .drive_o(drive_o),
    .init_sel_o(isel_o), .irq_o(irq_o));

  iad_contact_model iad_contact_model_inst (
    .clk_i(clk_i), .close_i(close), .drive_i(drive_o),
    .sense_o(sense), .rises_o(rises));

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic set(input logic b);
    @(posedge clk_i);
    close <= b;
  endtask

  // Classic single cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, w, a, 4'hf, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      end_of_test();
    end else begin
      q = wb_dat_o;
      req <= '0;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0);
  endtask

  task automatic rst(input logic [1:0] s, input logic l, input logic e);
    @(posedge clk_i);
    rst_i <= 1'b1;
    isel  <= s;
    last  <= l;
    wt(6);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(drive_o, e);
  endtask

  task automatic t_regs;
    rd(A_CTRL); chk(q, 32'h240);
    rd(A_LOW); chk(q, 32'h3e8);
    rd(A_HIGH); chk(q, 32'h3e8);
    rd(A_THR); chk(q, 32'h0);
    chk(isel_o, INIT_LAST);
    rd(8'h40); chk(q, 32'h0);
    set(1'b1);
    wt(10);
    rd(A_STAT); chk(q[0], 1'b0);
    set(1'b0);
    wt(10);
  endtask

  task automatic t_lvl(input logic [9:0] c, input logic a, input logic b);
    wr(A_CTRL, {22'h0, c});
    wt(10);
    set(1'b1);
    wt(10);
    chk(drive_o, a);
    chk(isel_o, c[9:8]);
    set(1'b0);
    wt(10);
    chk(drive_o, b);
  endtask

  task automatic t_irq;
    wr(A_MASK, 32'h3); wt(1); chk(irq_o, 1'b1);
    rd(A_IRQ); chk(q[2:0], 3'h3);
    wr(A_IRQ, 32'h1);
    rd(A_IRQ); chk(q[2:0], 3'h2);
    wr(A_MASK, 32'h1); wt(1); chk(irq_o, 1'b0);
    wr(A_MASK, 32'h2); wt(1); chk(irq_o, 1'b1);
    wr(A_IRQ, 32'h2); wt(1); chk(irq_o, 1'b0);
    wr(A_MASK, 32'h0);
  endtask

  task automatic t_cnt(input logic [9:0] c, input logic [15:0] e);
    wr(A_CTRL, {22'h0, c});
    wr(A_STAT, 32'h1);
    set(1'b1); wt(10);
    rd(A_STAT); chk(q[31:16], e);
    set(1'b0); wt(10);
    rd(A_STAT); chk(q[31:16], 16'h1);
  endtask

  task automatic t_pulse;
    int hi;
    int r0;
    wr(A_HIGH, 32'h2);
    wr(A_LOW, 32'h3);
    wr(A_CTRL, 32'h269);
    set(1'b1);
    wt(20);
    r0 = rises;
    hi = 0;
    repeat (500) begin
      @(posedge clk_i);
      if (drive_o === 1'b1) hi++;
    end
    chk(hi > 150 && hi < 250, 1'b1);
    chk(rises - r0 > 7 && rises - r0 < 13, 1'b1);
    // Clock enable low freezes the pulse train
    @(posedge clk_i);
    ce <= 1'b0;
    wt(2);
    r0 = rises;
    hi = drive_o;
    wt(100);
    chk(drive_o, hi);
    chk(rises, r0);
    ce <= 1'b1;
    set(1'b0); wt(20);
    chk(drive_o, 1'b0);
  endtask

  task automatic t_time;
    wr(A_DLY, 32'h1);
    wr(A_HOLD, 32'h1);
    wr(A_CTRL, 32'h249);
    set(1'b1);
    wt(900); chk(drive_o, 1'b0);
    wt(200); chk(drive_o, 1'b1);
    wt(9700); chk(drive_o, 1'b1);
    wt(400); chk(drive_o, 1'b0);
    rd(A_IRQ); chk(q[2], 1'b1);
  endtask

  initial begin
    wt(6);
    rst_i <= 1'b0;
    rst(INIT_HIGH, 1'b0, 1'b1);
    rst(INIT_LAST, 1'b1, 1'b1);
    rst(INIT_LOW, 1'b1, 1'b0);
    t_regs();
    t_lvl(10'h241, 1'b0, 1'b0);
    t_lvl(10'h249, 1'b1, 1'b0);
    t_lvl(10'h219, 1'b0, 1'b1);
    t_lvl(10'h24d, 1'b0, 1'b1);
    t_irq();
    wr(A_THR, 32'h2);
    t_cnt(10'h24b, 16'h1);
    chk(q[0], 1'b0);
    set(1'b1); wt(10);
    set(1'b0); wt(10);
    rd(A_STAT); chk(q[0], 1'b1);
    t_cnt(10'h24f, 16'h0);
    t_pulse();
    t_time();
    end_of_test();
  end
endmodule // iad_alarm_out_bench

// ===== dv/iad_contact_model.sv
// Far side model: contact closing the sense input and slave counting drive rises
`timescale 1ns/1ps
module iad_contact_model (
  input  wire logic        clk_i,
  input  wire logic        close_i,
  input  wire logic        drive_i,
  output logic             sense_o,
  output logic [15:0]      rises_o
);
  logic drive_q;
  initial begin
    sense_o = 1'b0;
    rises_o = 16'h0000;
    drive_q = 1'b0;
  end
  // Contact level settles one clock after the request, clean of bounce
  always @(posedge clk_i) begin
    sense_o <= close_i;
    drive_q <= drive_i;
    if (drive_i === 1'b1 && drive_q === 1'b0) begin
      rises_o <= rises_o + 16'h0001;
    end
  end
endmodule // iad_contact_model
